/* hw/bevi_buffer_events.sv */
// Buffer event flags, interrupt enables and AXI4-Lite register slave
//
// Chosen here: register access over AXI4-Lite.
`default_nettype none

module bevi_buffer_events (
   // Clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     reset,
   // AXI4-Lite write address and data
   input  wire logic [bevi_pkg::AW-1:0]  s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   // AXI4-Lite read
   input  wire logic [bevi_pkg::AW-1:0]  s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   // Buffer events from the engines, one-cycle pulses
   input  wire logic                     tx_ready_evt,
   input  wire logic                     tx_starve_evt,
   input  wire logic                     rx_dma_done_evt,
   input  wire logic                     rx_lost_evt,
   input  wire logic                     addr_match_evt,
   input  wire logic                     rx_early_evt,
   // Collision sensing
   input  wire logic                     tx_active,
   input  wire logic                     col_pin,
   // Enable preload from the configuration memory
   input  wire logic                     cfg_preload_valid,
   input  wire logic [15:0]              cfg_preload_data,
   // Results
   output logic                          irq,
   output logic                          tx_abandon
);
   typedef struct packed {
      bevi_pkg::bevi_wst_t wst;
      bevi_pkg::bevi_rst_t rst;
      logic                aw_got;
      logic [9:0]          aw_idx;
      logic                w_got;
      logic [15:0]         w_data;
      logic [1:0]          w_strb;
      logic [1:0]          bresp;
      logic [1:0]          rresp;
      logic [31:0]         rdata;
      logic [15:0]         cfg;
      logic [15:0]         evt;
      logic [1:0]          wrap;
      logic                irq;
      logic                abandon;
      logic                col_meta;
      logic                col_sync;
      logic                col_prev;
   } bevi_state_t;

   bevi_state_t st_ff;
   bevi_state_t nxt_st;

   logic        aw_take;
   logic        w_take;
   logic        wr_do;
   logic [9:0]  wr_idx;
   logic [15:0] wr_data;
   logic [1:0]  wr_strb;
   logic        wr_cfg;
   logic        soft_req;
   logic        ar_take;
   logic [9:0]  rd_idx;
   logic        rd_evt;
   logic        rd_wrap;
   logic        col_edge;
   logic        early_swap;
   logic [15:0] evt_set;

   bevi_cnt_if col_if ();
   bevi_cnt_if lost_if ();

   // Handshake outputs straight from the channel states
   assign s_axi_awready = (st_ff.wst == bevi_pkg::W_IDLE) && !st_ff.aw_got;
   assign s_axi_wready  = (st_ff.wst == bevi_pkg::W_IDLE) && !st_ff.w_got;
   assign s_axi_bvalid  = (st_ff.wst == bevi_pkg::W_RESP);
   assign s_axi_arready = (st_ff.rst == bevi_pkg::R_IDLE);
   assign s_axi_rvalid  = (st_ff.rst == bevi_pkg::R_RESP);

   // Registered data outputs
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_rresp = st_ff.rresp;
   assign s_axi_rdata = st_ff.rdata;
   assign irq         = st_ff.irq;
   assign tx_abandon  = st_ff.abandon;

   // Address and data may arrive in either order; a held one is used first
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take  = s_axi_wvalid && s_axi_wready;
   assign wr_idx  = st_ff.aw_got ? st_ff.aw_idx : s_axi_awaddr[11:2];
   assign wr_data = st_ff.w_got ? st_ff.w_data : s_axi_wdata[15:0];
   assign wr_strb = st_ff.w_got ? st_ff.w_strb : s_axi_wstrb[1:0];
   assign wr_do   = (st_ff.wst == bevi_pkg::W_IDLE) && (st_ff.aw_got || aw_take)
                    && (st_ff.w_got || w_take);
   assign wr_cfg  = wr_do && (wr_idx == bevi_pkg::CFG_IDX);

   assign soft_req = wr_cfg && wr_strb[0] && wr_data[bevi_pkg::BIT_SOFT];

   // Read decode and its clearing side effects
   assign ar_take = s_axi_arvalid && s_axi_arready;
   assign rd_idx  = s_axi_araddr[11:2];
   assign rd_evt  = ar_take && (rd_idx == bevi_pkg::EVT_IDX);
   assign rd_wrap = ar_take && (rd_idx == bevi_pkg::WRAP_IDX);

   assign col_edge     = st_ff.col_sync && !st_ff.col_prev;
   assign col_if.inc   = col_edge && tx_active;
   assign col_if.clr   = ar_take && (rd_idx == bevi_pkg::COLCNT_IDX);
   assign lost_if.inc  = rx_lost_evt;
   assign lost_if.clr  = ar_take && (rd_idx == bevi_pkg::LOSTCNT_IDX);

   // early event takes over the address match
   assign early_swap = rx_early_evt && st_ff.cfg[bevi_pkg::BIT_ADDR];

   // Event sources into their flag positions
   always_comb begin
      evt_set = 16'h0000;
      evt_set[bevi_pkg::BIT_SOFT]   = soft_req;
      evt_set[bevi_pkg::BIT_DMA]    = rx_dma_done_evt;
      evt_set[bevi_pkg::BIT_TXRDY]  = tx_ready_evt;
      evt_set[bevi_pkg::BIT_STARVE] = tx_starve_evt;
      evt_set[bevi_pkg::BIT_LOST]   = rx_lost_evt;
      evt_set[bevi_pkg::BIT_EARLY]  = rx_early_evt;
      evt_set[bevi_pkg::BIT_ADDR]   = addr_match_evt;
   end

   // Next state of the whole block
   always_comb begin
      nxt_st = st_ff;
      // Collision pin crosses in on two flops before the edge detector
      nxt_st.col_meta = col_pin;
      nxt_st.col_sync = st_ff.col_meta;
      nxt_st.col_prev = st_ff.col_sync;
      nxt_st.abandon  = tx_starve_evt;
      // Write channel capture
      if (aw_take) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.aw_idx = s_axi_awaddr[11:2];
      end
      if (w_take) begin
         nxt_st.w_got  = 1'b1;
         nxt_st.w_data = s_axi_wdata[15:0];
         nxt_st.w_strb = s_axi_wstrb[1:0];
      end
      // Read-only targets accept and ignore writes; unmapped ones are refused
      if (wr_do) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got  = 1'b0;
         nxt_st.wst    = bevi_pkg::W_RESP;
         case (wr_idx)
            bevi_pkg::CFG_IDX,
            bevi_pkg::EVT_IDX,
            bevi_pkg::COLCNT_IDX,
            bevi_pkg::LOSTCNT_IDX,
            bevi_pkg::WRAP_IDX: begin
               nxt_st.bresp = bevi_pkg::RESP_OKAY;
            end
            default: begin
               nxt_st.bresp = bevi_pkg::RESP_SLVERR;
            end
         endcase
      end
      if ((st_ff.wst == bevi_pkg::W_RESP) && s_axi_bready) begin
         nxt_st.wst = bevi_pkg::W_IDLE;
      end
      // preload, a host write in the same cycle wins
      if (cfg_preload_valid) begin
         nxt_st.cfg = cfg_preload_data & bevi_pkg::CFG_WMASK;
      end
      if (wr_cfg) begin
         nxt_st.cfg = {wr_strb[1] ? wr_data[15:8] : st_ff.cfg[15:8],
                       wr_strb[0] ? wr_data[7:0] : st_ff.cfg[7:0]} & bevi_pkg::CFG_WMASK;
      end
      // Read channel, data captured at the taking edge
      if (ar_take) begin
         nxt_st.rst   = bevi_pkg::R_RESP;
         nxt_st.rresp = bevi_pkg::RESP_OKAY;
         case (rd_idx)
            bevi_pkg::CFG_IDX: begin
               nxt_st.rdata = {16'h0000, st_ff.cfg[15:6], bevi_pkg::CFG_ID};
            end
            bevi_pkg::EVT_IDX: begin
               nxt_st.rdata = {16'h0000, st_ff.evt[15:6], bevi_pkg::EVT_ID};
            end
            bevi_pkg::COLCNT_IDX: begin
               nxt_st.rdata = {16'h0000, col_if.count, bevi_pkg::COL_ID};
            end
            bevi_pkg::LOSTCNT_IDX: begin
               nxt_st.rdata = {16'h0000, lost_if.count, bevi_pkg::LOST_ID};
            end
            bevi_pkg::WRAP_IDX: begin
               nxt_st.rdata = {30'h00000000, st_ff.wrap};
            end
            default: begin
               nxt_st.rdata = 32'h00000000;
               nxt_st.rresp = bevi_pkg::RESP_SLVERR;
            end
         endcase
      end
      if ((st_ff.rst == bevi_pkg::R_RESP) && s_axi_rready) begin
         nxt_st.rst = bevi_pkg::R_IDLE;
      end
      // read clears, a new event in the same cycle survives
      nxt_st.evt = rd_evt ? 16'h0000 : st_ff.evt;
      // address match withdrawn when the early event lands
      if (early_swap) begin
         nxt_st.evt[bevi_pkg::BIT_ADDR] = 1'b0;
      end
      nxt_st.evt = (nxt_st.evt | evt_set) & bevi_pkg::EVT_MASK;
      // counter wrap warnings, cleared by their own read
      nxt_st.wrap = (rd_wrap ? 2'b00 : st_ff.wrap) | {lost_if.wrap, col_if.wrap};
      // single level request, soft flag needs no enable
      nxt_st.irq = (|(nxt_st.evt & (nxt_st.cfg | 16'h0040)))
                   || (nxt_st.wrap[0] && nxt_st.cfg[bevi_pkg::BIT_COLW])
                   || (nxt_st.wrap[1] && nxt_st.cfg[bevi_pkg::BIT_LOSTW]);
      if (reset) begin
         nxt_st     = '0;
         nxt_st.cfg = bevi_pkg::CFG_RST & bevi_pkg::CFG_WMASK;
         nxt_st.evt = bevi_pkg::EVT_RST & bevi_pkg::EVT_MASK;
      end
   end

   // State register
   always_ff @(posedge core_clk) begin
      st_ff <= nxt_st;
   end

   // Collision counter
   bevi_wrap_counter u_col_cnt (
      .core_clk (core_clk),
      .reset    (reset),
      .cnt      (col_if.ctr)
   );

   // Lost frame counter
   bevi_wrap_counter u_lost_cnt (
      .core_clk (core_clk),
      .reset    (reset),
      .cnt      (lost_if.ctr)
   );

   a_soft_irq_set: assert property (
      @(posedge core_clk) disable iff (reset)
      soft_req |=> st_ff.evt[bevi_pkg::BIT_SOFT] && irq)
      else $error("soft request did not raise irq");

   a_cfg_ident: assert property (
      @(posedge core_clk) disable iff (reset)
      ar_take && rd_idx == bevi_pkg::CFG_IDX |=> s_axi_rvalid && s_axi_rdata[5:0] == 6'h0b)
      else $error("enable identifier wrong");

   a_evt_ident: assert property (
      @(posedge core_clk) disable iff (reset)
      ar_take && rd_idx == bevi_pkg::EVT_IDX |=> s_axi_rvalid && s_axi_rdata[5:0] == 6'h0c)
      else $error("event identifier wrong");

   a_evt_clear: assert property (
      @(posedge core_clk) disable iff (reset)
      rd_evt && evt_set == 16'h0000 |=> st_ff.evt == 16'h0000)
      else $error("event read did not clear");

   a_early_swap: assert property (
      @(posedge core_clk) disable iff (reset)
      early_swap && !addr_match_evt |=> !st_ff.evt[bevi_pkg::BIT_ADDR] && st_ff.evt[bevi_pkg::BIT_EARLY])
      else $error("early event did not replace address match");

   a_starve_flag: assert property (
      @(posedge core_clk) disable iff (reset)
      tx_starve_evt |=> st_ff.evt[bevi_pkg::BIT_STARVE] && tx_abandon ##1 !tx_abandon || $past(tx_starve_evt))
      else $error("underrun not flagged");

   a_irq_enabled: assert property (
      @(posedge core_clk) disable iff (reset)
      tx_ready_evt && st_ff.cfg[bevi_pkg::BIT_TXRDY] && !wr_cfg && !cfg_preload_valid |=> irq)
      else $error("enabled event gave no irq");

   a_irq_quiet: assert property (
      @(posedge core_clk) disable iff (reset)
      st_ff.evt == 16'h0000 && st_ff.wrap == 2'b00 |-> !irq)
      else $error("irq without pending event");

   a_cfg_reset: assert property (
      @(posedge core_clk) disable iff (reset)
      $past(reset) |-> st_ff.cfg == 16'h0000 && st_ff.evt == 16'h0000 && !irq)
      else $error("reset state wrong");

   a_col_count: assert property (
      @(posedge core_clk) disable iff (reset)
      col_if.inc && !col_if.clr |=> col_if.count == 10'($past(col_if.count) + 10'h001))
      else $error("collision not counted");

   // Write response held until taken
   a_bresp_hold: assert property (
      @(posedge core_clk) disable iff (reset)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
endmodule // bevi_buffer_events

`default_nettype wire

/* common/bevi_pkg.sv */
// Constants and types of the buffer event interrupt block
//
// Contract
// - Each enable bit gates its matching buffer event onto the interrupt.
// - Low six bits read 001011 for enables and 001100 for events.
// - Writing one to soft_irq_request sets soft_irq_flag (bit 6) once.
// - Receive slave-DMA completion sets rx_dma_done_flag at bit 7.
// - Ready to accept a transmit frame sets tx_ready_flag at bit 8.
// - Transmit underrun sets tx_starve_flag at bit 9 and abandons the frame.
// - Lost receive frames set rx_lost_flag at bit 10.
// - First 128 received bytes set rx_early_flag at bit 11.
// - Collision counter stepping 1FFh to 200h interrupts when enabled.
// - Collision counter counts collision input activations during transmit.
// - Lost counter counts each miss; 1FFh to 200h interrupts when enabled.
// - Destination address match sets addr_match_flag at bit 15, before early.
// - With addr_match_enable set, early event replaces address match flag.
// - Reading the event register clears it; host handles every returned bit.
// - Enables reset clear with identifier; optional preload may set them.
// - Event register resets clear with only its identifier.
`default_nettype none

package bevi_pkg;
   // Register indices, byte address is four times the index
   localparam logic [9:0]  CFG_IDX     = 10'h10a;
   localparam logic [9:0]  EVT_IDX     = 10'h12c;
   localparam logic [9:0]  COLCNT_IDX  = 10'h140;
   localparam logic [9:0]  LOSTCNT_IDX = 10'h141;
   localparam logic [9:0]  WRAP_IDX    = 10'h142;
   localparam int unsigned AW          = 12;
   // Identifiers and reset values
   localparam logic [5:0]  CFG_ID      = 6'h0b;
   localparam logic [5:0]  EVT_ID      = 6'h0c;
   localparam logic [5:0]  LOST_ID     = 6'h10;
   localparam logic [5:0]  COL_ID      = 6'h12;
   localparam logic [15:0] CFG_RST     = 16'h000b;
   localparam logic [15:0] EVT_RST     = 16'h000c;
   // Writable enable bits and live event bits
   localparam logic [15:0] CFG_WMASK   = 16'hbf80;
   localparam logic [15:0] EVT_MASK    = 16'h8fc0;
   // Bit positions
   localparam int unsigned BIT_SOFT    = 6;
   localparam int unsigned BIT_DMA     = 7;
   localparam int unsigned BIT_TXRDY   = 8;
   localparam int unsigned BIT_STARVE  = 9;
   localparam int unsigned BIT_LOST    = 10;
   localparam int unsigned BIT_EARLY   = 11;
   localparam int unsigned BIT_COLW    = 12;
   localparam int unsigned BIT_LOSTW   = 13;
   localparam int unsigned BIT_ADDR    = 15;
   // Event counters
   localparam int unsigned CNT_W       = 10;
   localparam logic [9:0]  WRAP_FROM   = 10'h1ff;
   // Bus answers
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [0:0] {W_IDLE = 1'b0, W_RESP = 1'b1} bevi_wst_t;
   typedef enum logic [0:0] {R_IDLE = 1'b0, R_RESP = 1'b1} bevi_rst_t;
endpackage

`default_nettype wire

/* common/bevi_cnt_if.sv */
// Link between the main block and one wrapping event counter
`default_nettype none

interface bevi_cnt_if;
   logic                       inc;
   logic                       clr;
   logic [bevi_pkg::CNT_W-1:0] count;
   logic                       wrap;
   modport ctr  (input inc, input clr, output count, output wrap);
   modport user (output inc, output clr, input count, input wrap);
endinterface

`default_nettype wire

/* hw/bevi_wrap_counter.sv */
// Clear-on-read event counter with a half-way wrap warning
`default_nettype none

module bevi_wrap_counter (
   // Clock and reset
   input wire logic   core_clk,
   input wire logic   reset,
   // Counter link
   bevi_cnt_if.ctr    cnt
);
   typedef struct packed {
      logic [bevi_pkg::CNT_W-1:0] count;
   } bevi_cnt_state_t;

   bevi_cnt_state_t st_ff;
   bevi_cnt_state_t nxt_st;

   // Warning fires on the step into the upper half, long before the wrap;
   // a clearing read in the same cycle restarts at one, so no warning then
   assign cnt.wrap  = cnt.inc && !cnt.clr && (st_ff.count == bevi_pkg::WRAP_FROM);
   assign cnt.count = st_ff.count;

   // A count arriving with the clearing read survives as one
   always_comb begin
      nxt_st = st_ff;
      if (cnt.clr) begin
         nxt_st.count = '0;
      end
      if (cnt.inc) begin
         nxt_st.count = nxt_st.count + 10'h001;
      end
      if (reset) begin
         nxt_st = '0;
      end
   end

   // State register
   always_ff @(posedge core_clk) begin
      st_ff <= nxt_st;
   end

   a_wrap_point: assert property (
      @(posedge core_clk) disable iff (reset)
      cnt.inc && !cnt.clr && st_ff.count == 10'h1ff |-> cnt.wrap ##1 st_ff.count == 10'h200)
      else $error("wrap warning missing at 1ff");
endmodule // bevi_wrap_counter

`default_nettype wire

/* verif/bevi_host_model.sv */
// Host processor model: AXI4-Lite master reached through one access task
`default_nettype none

module bevi_host_model (
   // Clock
   input  wire logic        core_clk,
   // Write channels
   output logic [11:0]      awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   // Read channels
   output logic [11:0]      araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus; each register is one whole word, so every strobe is set
   initial begin
      {awaddr, araddr, wdata} = 56'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      wstrb = 4'hf;
   end
   // No receive DMA mode exists here, so the early enable is free
   // Sampled at the falling edge, which holds what the next rising edge takes
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] resp, output logic hung);
      logic [4:0] hs;
      logic       late;
      hung = 1'b1;
      @(posedge core_clk);
      if (wr) begin
         awaddr <= a;
         wdata  <= d;
         {awvalid, wvalid} <= 2'h3;
      end else begin
         araddr <= a;
         {arvalid, rready} <= 2'h3;
      end
      for (int n = 0; n < 64 && hung; n++) begin
         @(negedge core_clk);
         hs   = {awvalid & awready, wvalid & wready, arvalid & arready, bvalid & bready, rvalid & rready};
         q    = rdata;
         resp = wr ? bresp : rresp;
         late = wr & bvalid & !bready;
         @(posedge core_clk);
         // Write answer taken one cycle late, so the slave has to hold it
         if (late) bready <= 1'b1;
         if (hs[4]) awvalid <= 1'b0;
         if (hs[3]) wvalid <= 1'b0;
         if (hs[2]) arvalid <= 1'b0;
         // Released lines show the inverse, never a stale copy of the request
         if (hs[1:0] != 2'h0) begin
            {bready, rready} <= 2'h0;
            {awaddr, araddr, wdata} <= {~a, ~a, ~d};
            hung = 1'b0;
         end
      end
   endtask
endmodule // bevi_host_model

`default_nettype wire

/* verif/bevi_buffer_events_test.sv */
// Self-checking bench for the buffer event interrupt block
`default_nettype none

module bevi_buffer_events_test;
   timeunit 1ns;
   timeprecision 1ps;
   // Addresses, reset words and the normal answer
   localparam logic [11:0] CFG_A = {bevi_pkg::CFG_IDX, 2'h0};
   localparam logic [11:0] EVT_A = {bevi_pkg::EVT_IDX, 2'h0};
   localparam logic [31:0] CFG_W = {16'h0, bevi_pkg::CFG_RST};
   localparam logic [31:0] EVT_W = {16'h0, bevi_pkg::EVT_RST};
   localparam logic [1:0]  OK    = bevi_pkg::RESP_OKAY;
   // Flag bit of each engine event, in the order of evt
   localparam int unsigned POS [6] = '{bevi_pkg::BIT_TXRDY, bevi_pkg::BIT_STARVE, bevi_pkg::BIT_DMA,
                                      bevi_pkg::BIT_LOST, bevi_pkg::BIT_ADDR, bevi_pkg::BIT_EARLY};
   // Bench signals
   logic        core_clk = 1'b0;
   logic        reset = 1'b1;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [5:0]  evt = 6'h0;
   logic        tx_active = 1'b0, col_pin = 1'b0, pre_valid = 1'b0;
   logic [15:0] pre_data = 16'h0;
   logic        irq, tx_abandon;
   int          miscompares = 0, check_count = 0;
   // 50 MHz core clock
   always #10 core_clk = ~core_clk;
   // Design, with engine events and collision sensing driven here
   bevi_buffer_events bevi_buffer_events_i (
      .core_clk(core_clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_ready_evt(evt[0]),
      .tx_starve_evt(evt[1]), .rx_dma_done_evt(evt[2]), .rx_lost_evt(evt[3]), .addr_match_evt(evt[4]),
      .rx_early_evt(evt[5]), .tx_active(tx_active), .col_pin(col_pin), .cfg_preload_valid(pre_valid),
      .cfg_preload_data(pre_data), .irq(irq), .tx_abandon(tx_abandon)
   );
   // Host side of the register bus
   bevi_host_model bevi_host_model_i (
      .core_clk(core_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready)
   );
   // Counts, verdict and end of run
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // One counted comparison
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Register access; a read compares its data, both compare the answer; a hang ends the run
   task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [31:0] q;
      logic [1:0]  resp;
      logic        hung;
      bevi_host_model_i.bus(wr, a, d, q, resp, hung);
      if (!wr) check($sformatf("rdata %h", a), d, q);
      check($sformatf("resp %h", a), {30'h0, er}, {30'h0, resp});
      if (hung !== 1'b0) begin
         miscompares++;
         close_out();
      end
   endtask
   // One-cycle engine pulse
   task automatic pulse(input logic [5:0] m);
      @(posedge core_clk);
      evt <= m;
      @(posedge core_clk);
      evt <= 6'h0;
   endtask
   // Interrupt line, looked at once the edge has settled
   task automatic irq_is(input logic e);
      @(negedge core_clk);
      check("irq", {31'h0, e}, {31'h0, irq});
   endtask
   // 512 counted events; the warning belongs to the 1FFh to 200h step only
   task automatic wrap_run(input logic lost);
      acc(1'b1, CFG_A, lost ? 32'h2000 : 32'h1000, OK);
      for (int n = 0; n < 512; n++) begin
         if (n == 511) irq_is(1'b0);
         @(posedge core_clk);
         evt[3]  <= lost;
         col_pin <= !lost;
         @(posedge core_clk);
         evt[3]  <= 1'b0;
         col_pin <= 1'b0;
         repeat (6) @(posedge core_clk);
      end
      irq_is(1'b1);
      acc(1'b0, {bevi_pkg::WRAP_IDX, 2'h0}, lost ? 32'h2 : 32'h1, OK);
      acc(1'b0, {lost ? bevi_pkg::LOSTCNT_IDX : bevi_pkg::COLCNT_IDX, 2'h0},
          {26'h200, lost ? 6'h10 : 6'h12}, OK);
      irq_is(1'b0);
   endtask
   // Main sequence
   initial begin
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      acc(1'b0, CFG_A, CFG_W, OK);
      acc(1'b0, EVT_A, EVT_W, OK);
      for (int i = 0; i < 6; i++) begin
         pulse(6'h1 << i);
         irq_is(1'b0);
         check("tx_abandon", {31'h0, i == 1}, {31'h0, tx_abandon});
         acc(1'b0, EVT_A, EVT_W | (32'h1 << POS[i]), OK);
         acc(1'b0, EVT_A, EVT_W, OK);
         acc(1'b1, CFG_A, 32'h1 << POS[i], OK);
         acc(1'b0, CFG_A, CFG_W | (32'h1 << POS[i]), OK);
         pulse(6'h1 << i);
         irq_is(1'b1);
         acc(1'b0, EVT_A, EVT_W | (32'h1 << POS[i]), OK);
         irq_is(1'b0);
      end
      acc(1'b1, CFG_A, 32'h40, OK);
      irq_is(1'b1);
      acc(1'b0, CFG_A, CFG_W, OK);
      acc(1'b0, EVT_A, EVT_W | 32'h40, OK);
      acc(1'b0, EVT_A, EVT_W, OK);
      acc(1'b1, CFG_A, 32'h8000, OK);
      pulse(6'h10);
      irq_is(1'b1);
      pulse(6'h20);
      irq_is(1'b0);
      acc(1'b0, EVT_A, EVT_W | 32'h800, OK);
      // Unmapped place answers an error, both ways
      acc(1'b1, 12'h000, 32'h0, bevi_pkg::RESP_SLVERR);
      acc(1'b0, 12'h000, 32'h0, bevi_pkg::RESP_SLVERR);
      @(posedge core_clk);
      pre_valid <= 1'b1;
      pre_data  <= 16'hffbf;
      @(posedge core_clk);
      pre_valid <= 1'b0;
      acc(1'b0, CFG_A, {16'h0, bevi_pkg::CFG_WMASK | bevi_pkg::CFG_RST}, OK);
      // lost counter holds the two rx_lost_evt pulses seen so far
      acc(1'b0, {bevi_pkg::LOSTCNT_IDX, 2'h0}, 32'h90, OK);
      // Mid-run reset drops the preloaded enables back to the reset word
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      acc(1'b0, CFG_A, CFG_W, OK);
      acc(1'b0, EVT_A, EVT_W, OK);
      tx_active <= 1'b1;
      wrap_run(1'b0);
      wrap_run(1'b1);
      close_out();
   end
endmodule // bevi_buffer_events_test

`default_nettype wire
